/* File: inc/pamc_consts.svh */
// register offsets, field positions, reset values and timing figures
`ifndef PAMC_CONSTS_SVH
`define PAMC_CONSTS_SVH

// ====================================================================
// register indices (byte address is four times the index)
`define PAMC_IDX_POLARITY 16'h0475
`define PAMC_IDX_MON_PERIOD 16'h0480
`define PAMC_IDX_MON_MODE 16'h0481

// ====================================================================
// field positions
`define PAMC_POL_FORCE_BIT 12
`define PAMC_POL_VALUE_BIT 13
`define PAMC_PERIOD_MSB 3
`define PAMC_MODE_PERIODIC_BIT 1
`define PAMC_MODE_START_BIT 0

// ====================================================================
// reset values and period field mask
`define PAMC_RST_POLARITY 16'h0000
`define PAMC_RST_MON_PERIOD 16'h0002
`define PAMC_RST_MON_MODE 16'h00A2
`define PAMC_PERIOD_MASK 16'h000F

// ====================================================================
// timing
`define PAMC_STEP_MS 16
`define PAMC_CLK_KHZ 10000
`define PAMC_STEP_CYCLES (`PAMC_STEP_MS * `PAMC_CLK_KHZ)

`endif

/* File: inc/pamc_pkg.sv */
// types shared by the polarity and monitor configuration block
package pamc_pkg;

   // ====================================================================
   // register word
   typedef logic [15:0] pamc_word_t;

   // ====================================================================
   // monitor sequencer states, one-hot
   typedef enum logic [2:0]
   {
      PAMC_IDLE    = 3'b001,
      PAMC_MEASURE = 3'b010,
      PAMC_WAIT    = 3'b100
   } pamc_state_e;

endpackage

/* File: inc/pamc_tmr_if.sv */
// link between the monitor sequencer and its cycle timer
`timescale 1ns/10ps
interface pamc_tmr_if;
   logic start;
   logic [3:0] period;
   logic expire;

   // ====================================================================
   // sequencer side
   modport ctrl
   (
      output start,
      output period,
      input expire
   );

   // ====================================================================
   // timer side
   modport timer
   (
      input start,
      input period,
      output expire
   );
endinterface

/* File: rtl/pamc_timer.sv */
// monitor cycle timer counting whole sampling steps
`timescale 1ns/10ps
module pamc_timer
   import pamc_pkg::*;
#(
   parameter int STEP_CYCLES = 160000,
   parameter int STEP_W = $clog2(STEP_CYCLES + 1)
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   pamc_tmr_if.timer tmr
);

   logic [STEP_W-1:0] step_reg;
   logic [STEP_W-1:0] step_next;
   logic [3:0] left_reg;
   logic [3:0] left_next;
   logic expire_reg;
   logic expire_next;

   // ====================================================================
   // next step and remaining code count
   always_comb
   begin
      step_next = step_reg;
      left_next = left_reg;
      expire_next = 1'b0;
      if (tmr.start)
      begin
         step_next = STEP_W'(STEP_CYCLES - 1);
         // zero code runs as one step
         left_next = (tmr.period == 4'h0) ? 4'h1 : tmr.period;
      end
      else if (left_reg != 4'h0)
      begin
         if (step_reg == '0)
         begin
            left_next = left_reg - 4'h1;
            step_next = STEP_W'(STEP_CYCLES - 1);
            expire_next = (left_reg == 4'h1);
         end
         else
         begin
            step_next = step_reg - STEP_W'(1);
         end
      end
   end

   // ====================================================================
   // timer state
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         step_reg <= '0;
         left_reg <= 4'h0;
         expire_reg <= 1'b0;
      end
      else
      begin
         step_reg <= step_next;
         left_reg <= left_next;
         expire_reg <= expire_next;
      end
   end

   assign tmr.expire = expire_reg;

endmodule // pamc_timer

/* File: rtl/pamc_top.sv */
// polarity override and temperature / supply monitor configuration
`timescale 1ns/10ps
`include "pamc_consts.svh"
module pamc_top
   import pamc_pkg::*;
#(
   parameter int STEP_CYCLES = `PAMC_STEP_CYCLES,
   parameter int ADDR_W = 16
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [15:0] rdata_out,
   input wire logic auto_polarity_in,
   output logic line_polarity_out,
   output logic auto_correct_en_out,
   input wire logic monitor_done_in,
   output logic monitor_trigger_out,
   output logic monitor_busy_out
);

   // ====================================================================
   // address decode
   localparam logic [ADDR_W-1:0] ADDR_POLARITY = ADDR_W'({`PAMC_IDX_POLARITY, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_PERIOD = ADDR_W'({`PAMC_IDX_MON_PERIOD, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_MODE = ADDR_W'({`PAMC_IDX_MON_MODE, 2'b00});

   logic sel_polarity;
   logic sel_period;
   logic sel_mode;

   // one select per mapped word
   assign sel_polarity = (addr_in == ADDR_POLARITY);
   assign sel_period = (addr_in == ADDR_PERIOD);
   assign sel_mode = (addr_in == ADDR_MODE);

   // ====================================================================
   // register file state
   pamc_word_t polarity_reg;
   pamc_word_t polarity_next;
   pamc_word_t period_reg;
   pamc_word_t period_next;
   pamc_word_t mode_reg;
   pamc_word_t mode_next;
   pamc_word_t rdata_reg;
   pamc_word_t rdata_next;

   // sequencer takes the pending start this cycle
   logic start_accept;
   pamc_word_t mode_view;

   // read view of the mode word
   assign mode_view = mode_reg;

   // next register contents and read answer
   always_comb
   begin
      polarity_next = polarity_reg;
      period_next = period_reg;
      mode_next = mode_reg;
      rdata_next = 16'h0000;
      // start is cleared by hardware once taken
      // self-clearing start
      if (start_accept)
      begin
         mode_next[`PAMC_MODE_START_BIT] = 1'b0;
      end
      if (write_in)
      begin
         if (sel_polarity)
         begin
            polarity_next = wdata_in;
         end
         if (sel_period)
         begin
            period_next = wdata_in & `PAMC_PERIOD_MASK;
         end
         if (sel_mode)
         begin
            // a written one sets, a written zero leaves it alone
            // zero write no effect
            mode_next[15:1] = wdata_in[15:1];
            mode_next[`PAMC_MODE_START_BIT] = mode_next[`PAMC_MODE_START_BIT]
               | wdata_in[`PAMC_MODE_START_BIT];
         end
      end
      if (read_in)
      begin
         if (sel_polarity)
         begin
            rdata_next = polarity_reg;
         end
         else if (sel_period)
         begin
            rdata_next = period_reg;
         end
         else if (sel_mode)
         begin
            rdata_next = mode_view;
         end
         else
         begin
            rdata_next = 16'h0000; // unmapped reads zero
         end
      end
   end

   // register file flops
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         polarity_reg <= `PAMC_RST_POLARITY;
         period_reg <= `PAMC_RST_MON_PERIOD;
         mode_reg <= `PAMC_RST_MON_MODE;
         rdata_reg <= 16'h0000;
      end
      else
      begin
         polarity_reg <= polarity_next;
         period_reg <= period_next;
         mode_reg <= mode_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;

   // ====================================================================
   // line polarity selection
   logic line_pol_reg;
   logic line_pol_next;
   logic auto_en_reg;
   logic auto_en_next;

   // choose forced or corrected polarity
   always_comb
   begin
      if (polarity_reg[`PAMC_POL_FORCE_BIT])
      begin
         auto_en_next = 1'b0;
         line_pol_next = polarity_reg[`PAMC_POL_VALUE_BIT];
      end
      else
      begin
         auto_en_next = 1'b1;
         line_pol_next = auto_polarity_in;
      end
   end

   // polarity outputs
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         line_pol_reg <= 1'b0;
         auto_en_reg <= 1'b1;
      end
      else
      begin
         line_pol_reg <= line_pol_next;
         auto_en_reg <= auto_en_next;
      end
   end

   assign line_polarity_out = line_pol_reg;
   assign auto_correct_en_out = auto_en_reg;

   // ====================================================================
   // measurement-done synchroniser and edge detect
   logic done_s1_reg;
   logic done_s2_reg;
   logic done_s3_reg;
   logic done_edge;

   // two flops before use, third for the edge
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         done_s1_reg <= 1'b0;
         done_s2_reg <= 1'b0;
         done_s3_reg <= 1'b0;
      end
      else
      begin
         done_s1_reg <= monitor_done_in;
         done_s2_reg <= done_s1_reg;
         done_s3_reg <= done_s2_reg;
      end
   end

   assign done_edge = done_s2_reg & ~done_s3_reg;

   // ====================================================================
   // cycle timer
   pamc_tmr_if tmr ();

   pamc_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_timer (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .tmr(tmr)
   );

   // ====================================================================
   // monitor sequencer
   pamc_state_e state_reg;
   pamc_state_e state_next;
   logic trigger_reg;
   logic trigger_next;
   logic busy_reg;
   logic busy_next;
   logic tmr_start_reg;
   logic tmr_start_next;
   logic periodic;

   assign periodic = mode_reg[`PAMC_MODE_PERIODIC_BIT];

   // next sequencer state
   always_comb
   begin
      state_next = state_reg;
      trigger_next = 1'b0;
      tmr_start_next = 1'b0;
      start_accept = 1'b0;
      case (state_reg)
         PAMC_IDLE:
         begin
            if (mode_reg[`PAMC_MODE_START_BIT])
            begin
               start_accept = 1'b1;
               trigger_next = 1'b1;
               state_next = PAMC_MEASURE;
            end
         end
         PAMC_MEASURE:
         begin
            if (done_edge)
            begin
               if (periodic)
               begin
                  tmr_start_next = 1'b1;
                  state_next = PAMC_WAIT;
               end
               else
               begin
                  state_next = PAMC_IDLE;
               end
            end
         end
         PAMC_WAIT:
         begin
            if (!periodic)
            begin
               state_next = PAMC_IDLE;
            end
            // an expiry left over from an older run is ignored while the timer reloads
            else if (tmr.expire && !tmr_start_reg)
            begin
               trigger_next = 1'b1;
               state_next = PAMC_MEASURE;
            end
         end
         default:
         begin
            state_next = PAMC_IDLE;
         end
      endcase
      busy_next = (state_next != PAMC_IDLE);
   end

   // sequencer flops
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= PAMC_IDLE;
         trigger_reg <= 1'b0;
         busy_reg <= 1'b0;
         tmr_start_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         trigger_reg <= trigger_next;
         busy_reg <= busy_next;
         tmr_start_reg <= tmr_start_next;
      end
   end

   // timer hookup and outputs
   assign tmr.start = tmr_start_reg;
   assign tmr.period = period_reg[`PAMC_PERIOD_MSB:0];
   assign monitor_trigger_out = trigger_reg;
   assign monitor_busy_out = busy_reg;

endmodule // pamc_top

/* File: verif/pamc_checker.sv */
// concurrent checks on the configuration block ports
`timescale 1ns/10ps
`include "pamc_consts.svh"
module pamc_checker
   import pamc_pkg::*;
#(
   parameter int STEP_CYCLES = 20
)
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [15:0] rdata_out,
   input wire logic auto_polarity_in,
   input wire logic line_polarity_out,
   input wire logic auto_correct_en_out,
   input wire logic monitor_done_in,
   input wire logic monitor_trigger_out,
   input wire logic monitor_busy_out
);
   // ==========
   // shadow of written fields
   localparam logic [15:0] A_POL = `PAMC_IDX_POLARITY << 2;
   localparam logic [15:0] A_PER = `PAMC_IDX_MON_PERIOD << 2;
   localparam logic [15:0] A_MODE = `PAMC_IDX_MON_MODE << 2;
   logic [1:0] pol_reg, pol_next;
   logic [3:0] per_reg, per_next;
   logic mode_reg, mode_next, done_reg;
   int gap_reg, gap_next;
   wire wm = write_in && addr_in == A_MODE;

   // next shadow values; gap counts cycles since the done pin last rose
   always_comb
   begin
      pol_next = pol_reg;
      per_next = per_reg;
      mode_next = mode_reg;
      gap_next = (gap_reg < 100000) ? gap_reg + 1 : gap_reg;
      if (monitor_done_in && !done_reg)
      begin
         gap_next = 0;
      end
      if (write_in && addr_in == A_POL)
         pol_next = wdata_in[13:12];
      if (write_in && addr_in == A_PER)
         per_next = wdata_in[3:0];
      if (wm)
      begin
         mode_next = wdata_in[1];
      end
   end

   // shadow registers
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pol_reg <= 2'h0;
         per_reg <= 4'h2;
         mode_reg <= 1'h1;
         done_reg <= 1'h0;
         gap_reg <= 0;
      end
      else
      begin
         pol_reg <= pol_next;
         per_reg <= per_next;
         mode_reg <= mode_next;
         done_reg <= monitor_done_in;
         gap_reg <= gap_next;
      end
   end

   // ==========
   // properties
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   force_value_a:
      assert property ($past(rst_n_in) && pol_reg[0] |=> !auto_correct_en_out
         && line_polarity_out == $past(pol_reg[1])) else $error("forced polarity wrong");
   auto_mode_a:
      assert property ($past(rst_n_in) && !pol_reg[0] |=> auto_correct_en_out
         && line_polarity_out == $past(auto_polarity_in)) else $error("auto polarity wrong");
   period_read_a:
      assert property (read_in && addr_in == A_PER |=> rdata_out == {12'h000, per_reg})
         else $error("period readback wrong");
   mode_read_a:
      assert property (read_in && addr_in == A_MODE |=> rdata_out[1] == mode_reg)
         else $error("periodic bit readback wrong");
   start_trig_a:
      assert property (wm && wdata_in[0] && !monitor_busy_out ##1 !monitor_busy_out
         |=> monitor_trigger_out && monitor_busy_out) else $error("start gave no trigger");
   trig_pulse_a:
      assert property (monitor_trigger_out |=> !monitor_trigger_out)
         else $error("trigger longer than one cycle");
   zero_start_a:
      assert property (wm && !wdata_in[0] && !monitor_busy_out ##1 !monitor_busy_out
         |=> !monitor_trigger_out) else $error("zero start triggered");
   // a trigger with busy already high the cycle before comes from the wait, not a start
   period_gap_a:
      assert property (monitor_trigger_out && $past(monitor_busy_out) |-> mode_reg
         && gap_reg >= per_reg * STEP_CYCLES && gap_reg <= per_reg * STEP_CYCLES + 12)
         else $error("periodic trigger timing wrong");

   // main scenarios reached
   cover property (monitor_trigger_out && mode_reg && $past(monitor_busy_out));
   cover property (pol_reg == 2'h3 && line_polarity_out);
   cover property (wm && !wdata_in[0]);
endmodule // pamc_checker

bind pamc_top pamc_checker #(.STEP_CYCLES(STEP_CYCLES)) pamc_checker_inst (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
   .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
   .auto_polarity_in(auto_polarity_in), .line_polarity_out(line_polarity_out),
   .auto_correct_en_out(auto_correct_en_out), .monitor_done_in(monitor_done_in),
   .monitor_trigger_out(monitor_trigger_out), .monitor_busy_out(monitor_busy_out));

/* File: verif/tb_top.sv */
// self-checking bench for the polarity and monitor configuration block
`timescale 1ns/10ps
`include "pamc_consts.svh"
module tb_top;
   import pamc_pkg::*;
   // ==========
   // signals and model state
   localparam int STEP = 20;
   localparam logic [15:0] A_POL = `PAMC_IDX_POLARITY << 2;
   localparam logic [15:0] A_PER = `PAMC_IDX_MON_PERIOD << 2;
   localparam logic [15:0] A_MODE = `PAMC_IDX_MON_MODE << 2;
   logic clock_in, rst_n_in, wr_s, rd_s, apol, lpol, acen, done, trig, busy, e;
   logic [15:0] addr, wdata, rdata, d, g;
   logic [31:0] r, rnd;
   logic [3:0] c;
   int fails, tests_run, seen, n, n0, i;

   pamc_top #(.STEP_CYCLES(STEP)) pamc_top_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .addr_in(addr), .wdata_in(wdata), .write_in(wr_s), .read_in(rd_s), .rdata_out(rdata),
      .auto_polarity_in(apol), .line_polarity_out(lpol), .auto_correct_en_out(acen),
      .monitor_done_in(done), .monitor_trigger_out(trig), .monitor_busy_out(busy));

   // clock and trigger counter
   initial
   begin
      clock_in = 1'h0;
      forever #50 clock_in = ~clock_in;
   end
   always @(negedge clock_in)
      if (trig === 1'h1)
         seen++;

   // ==========
   // helpers
   function logic [31:0] xs();
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return rnd;
   endfunction
   task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      tests_run++;
      if (got !== ex)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] v);
      addr <= a;
      wdata <= v;
      wr_s <= 1'h1;
      @(posedge clock_in);
      wr_s <= 1'h0;
      @(posedge clock_in);
   endtask
   task rchk(input logic [15:0] a, input logic [15:0] ex);
      addr <= a;
      rd_s <= 1'h1;
      @(posedge clock_in);
      rd_s <= 1'h0;
      @(negedge clock_in);
      chk("rdata", ex, rdata);
      @(posedge clock_in);
   endtask
   task wt(input logic want, input int lim);
      n = 0;
      do
      begin
         @(negedge clock_in);
         n++;
      end
      while ((want ? trig : !busy) !== 1'h1 && n < lim);
      if (n >= lim)
      begin
         fails++;
         $display("wrong value wait expected 1 seen 0");
         final_report;
      end
      else
      begin
         @(posedge clock_in);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ==========
   // main sequence
   initial
   begin
      {rst_n_in, wr_s, rd_s, apol, done, addr, wdata} = '0;
      {fails, tests_run} = '0;
      rnd = 32'h0000000A;
      repeat (12) @(posedge clock_in);
      rst_n_in <= 1'h1;
      @(posedge clock_in);
      rchk(A_POL, 16'h0000);
      rchk(A_PER, 16'h0002);
      rchk(A_MODE, 16'h00A2);
      chk("acen", 16'h0001, {15'h0000, acen});
      $display("test reset values done");
      for (i = 0; i < 8; i++)
      begin
         r = xs();
         d = {r[15:14], i[1:0], r[11:0]};
         apol <= r[16];
         wr(A_POL, d);
         @(negedge clock_in);
         e = d[12] ? d[13] : r[16];
         chk("lpol", {15'h0000, e}, {15'h0000, lpol});
         chk("acen", {15'h0000, !d[12]}, {15'h0000, acen});
         @(posedge clock_in);
         rchk(A_POL, d);
      end
      $display("test polarity done");
      for (i = 0; i < 6; i++)
      begin
         r = xs();
         c = (r[3:0] == 4'h0) ? 4'h1 : r[3:0];
         wr(A_PER, {r[15:4], c});
         rchk(A_PER, {12'h000, c});
      end
      wr(16'h1208, 16'hFFFF);
      rchk(16'h1208, 16'h0000);
      rchk(A_PER, {12'h000, c});
      $display("test period field done");
      n0 = seen;
      wr(A_MODE, 16'h00A1);
      wt(1'h1, 8);
      chk("delay", 16'h0001, 16'(n));
      rchk(A_MODE, 16'h00A0);
      done <= 1'h1;
      wt(1'h0, 12);
      done <= 1'h0;
      wr(A_MODE, 16'h00A0);
      repeat (10) @(posedge clock_in);
      chk("count", 16'(n0 + 1), 16'(seen));
      wr(A_MODE, 16'h00A1);
      wr(A_MODE, 16'h00A1);
      done <= 1'h1;
      wt(1'h1, 12);
      done <= 1'h0;
      repeat (4) @(posedge clock_in);
      done <= 1'h1;
      wt(1'h0, 12);
      done <= 1'h0;
      chk("count", 16'(n0 + 3), 16'(seen));
      $display("test single run done");
      wr(A_PER, {12'h000, c});
      wr(A_MODE, 16'h00A3);
      wt(1'h1, 8);
      for (i = 0; i < 2; i++)
      begin
         repeat (4) @(posedge clock_in);
         done <= 1'h1;
         wt(1'h1, 400);
         done <= 1'h0;
         chk("gap", 16'h0001, {15'h0000, n >= c * STEP && n <= c * STEP + 12});
      end
      repeat (4) @(posedge clock_in);
      done <= 1'h1;
      repeat (8) @(posedge clock_in);
      wr(A_MODE, 16'h00A0);
      wt(1'h0, 8);
      n0 = seen;
      repeat (c * STEP + 20) @(posedge clock_in);
      chk("count", 16'(n0), 16'(seen));
      done <= 1'h0;
      $display("test periodic done");
      final_report;
   end
endmodule // tb_top
